/* File: rtl/stlog_map.svh */
// Byte offsets, fixed values and sizes of the self-test result log and span table.
// Assumes byte offsets within a 512-byte log sector, 9 bits wide.
`ifndef STLOG_MAP_SVH
`define STLOG_MAP_SVH

`define STL_LOG_RESULT   8'h06
`define STL_LOG_SELECT   8'h09
`define STL_REV_LO       8'h01
`define STL_REV_HI       8'h00
`define STL_OFS_REV_HI   9'h001
`define STL_DESC_FIRST   9'h002
`define STL_DESC_LAST    9'h1F9
`define STL_DESC_BYTES   9'h018
`define STL_OFS_INDEX    9'h1FC
`define STL_OFS_CSUM     9'h1FF
`define STL_NSLOTS       21
`define STL_IDX_EMPTY    5'h00
`define STL_IDX_FIRST    5'h01
`define STL_IDX_LAST     5'h15
`define STL_NSPANS       5
`define STL_SPAN_FIRST   2
`define STL_SPAN_BYTES   16
`define STL_BOUND_BYTES  8
`define STL_SEL_LAST     81
`define STL_SEL_LAST_OFS 9'h051

`endif

/* File: rtl/stlog_pkg.sv */
// Types shared by the self-test result log and the selective span table.
// Assumes stlog_map.svh is on the include path.
`include "stlog_map.svh"

package stlog_pkg;

  // Stored part of one 24-byte descriptor; bytes 9..23 always read zero
  typedef struct packed {
    logic [7:0]  secNum;
    logic [7:0]  status;
    logic [15:0] hours;
    logic [7:0]  chkpt;
    logic [31:0] failLba;
  } stlog_desc_t;

  typedef enum logic [0:0] {
    STL_IDLE = 1'b0,
    STL_RUN  = 1'b1
  } stlog_phase_t;

  typedef struct packed {
    stlog_phase_t                       phase;
    logic [7:0]                         secNum;
    logic                               uncSeen;
    logic [31:0]                        uncLba;
    logic [4:0]                         idx;
    logic                               full;
    logic [7:0]                         sum;
    stlog_desc_t [`STL_NSLOTS-1:0]      mem;
    logic [7:0]                         rdData;
    logic                               rdValid;
    logic                               wrRefused;
    logic [`STL_NSPANS-1:0]             hitMask;
    logic [`STL_NSPANS-1:0]             defMask;
  } stlog_top_state_t;

  typedef struct packed {
    logic [`STL_SEL_LAST:0][7:0] img;
  } stlog_span_state_t;

endpackage

/* File: rtl/stlog_span_table.sv */
// Selective self-test log image: revision word and five start/end address spans.
// Assumes the parent gates writes; reads are combinational, the parent registers them.
`timescale 1ns/1ps
`include "stlog_map.svh"

module stlog_span_table
  import stlog_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   clkEn,
  // Byte access
  input  wire logic                   wrEn,
  input  wire logic [8:0]             byteOfs,
  input  wire logic [7:0]             wrData,
  output logic      [7:0]             rdByte,
  // Span query
  input  wire logic [63:0]            queryLba,
  output logic      [`STL_NSPANS-1:0] hitMask,
  output logic      [`STL_NSPANS-1:0] defMask
);

  stlog_span_state_t s_q;
  stlog_span_state_t s_d;

  function automatic logic inImage(input logic [8:0] ofs);
    return ofs <= `STL_SEL_LAST_OFS;
  endfunction

  // Bytes past the span area are not kept and read as zero
  always_comb begin
    s_d = s_q;
    if (wrEn && inImage(byteOfs)) begin
      s_d.img[byteOfs] = wrData;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign rdByte = inImage(byteOfs) ? s_q.img[byteOfs] : 8'h00;

  // Bounds are little-endian 8-byte fields, start then end
  for (genvar i = 0; i < `STL_NSPANS; i++) begin : g_span
    localparam int BASE = `STL_SPAN_FIRST + i * `STL_SPAN_BYTES;
    logic [63:0] startLba;
    logic [63:0] endLba;
    assign startLba   = s_q.img[BASE + `STL_BOUND_BYTES - 1 : BASE];
    assign endLba     = s_q.img[BASE + 2 * `STL_BOUND_BYTES - 1 : BASE + `STL_BOUND_BYTES];
    assign defMask[i] = (startLba != 64'h0) || (endLba != 64'h0);
    // Both ends are tested sectors
    assign hitMask[i] = defMask[i] && (queryLba >= startLba) && (queryLba <= endLba);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_span_undef;
    (hitMask & ~defMask) == '0;
  endproperty
  a_span_undef: assert property (p_span_undef) else $error("undefined span reported as hit");

  property p_span_ends;
    defMask[0] && (queryLba == g_span[0].startLba || queryLba == g_span[0].endLba)
      && (g_span[0].startLba <= g_span[0].endLba) |-> hitMask[0];
  endproperty
  a_span_ends: assert property (p_span_ends) else $error("span bound not treated as inclusive");

endmodule

/* File: rtl/stlog_result_log.sv */
// Self-test result log sector and selective span table, read by the host byte-wise; only the span table is host-written.
// Assumes test-engine and host strobes come from logic on core_clk; no synchronisers are needed.
//
// Function
// - Result log is one 512-byte sector at log address 06h.
// - Bytes 0 and 1 read revision 0001h.
// - 21 descriptors of 24 bytes lie back to back from byte 2.
// - Index byte 508 reads zero before any entry is logged.
// - Index points at newest entry, starts at one, wraps to one after 21.
// - Slots are overwritten circularly, oldest first.
// - Unused slots read all zero while fewer than 21 tests ran.
// - Descriptor byte 0 holds sector number given at test start.
// - Descriptor byte 1 holds execution status at completion.
// - Descriptor bytes 2-3 hold power-on hours at completion.
// - Descriptor byte 4 holds failure checkpoint code.
// - Descriptor bytes 5-8 hold first uncorrectable failing address.
// - Failing address is unspecified when no uncorrectable sector caused failure.
// - Selective log at 09h is writable and readable by host.
// - Selective log defines up to five spans.
// - Span bounds are inclusive at both ends.
// - A span with zero start and end is undefined and skipped.
// - Result log byte 511 makes the whole sector sum to zero.
`timescale 1ns/1ps
`include "stlog_map.svh"

module stlog_result_log
  import stlog_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   clkEn,
  // Host log access
  input  wire logic                   hostRdEn,
  input  wire logic                   hostWrEn,
  input  wire logic [7:0]             hostLogAddr,
  input  wire logic [8:0]             hostByteOfs,
  input  wire logic [7:0]             hostWrData,
  output logic      [7:0]             hostRdData,
  output logic                        hostRdValid,
  output logic                        hostWrRefused,
  // Self-test engine
  input  wire logic                   testStart,
  input  wire logic [7:0]             testSecNum,
  input  wire logic                   testUncErr,
  input  wire logic [31:0]            testUncLba,
  input  wire logic                   testDone,
  input  wire logic [7:0]             testStatus,
  input  wire logic [7:0]             testChkpt,
  input  wire logic [15:0]            powerOnHours,
  input  wire logic                   selectiveBusy,
  // Span query and log state
  input  wire logic [63:0]            spanQueryLba,
  output logic      [`STL_NSPANS-1:0] spanHitMask,
  output logic      [`STL_NSPANS-1:0] spanDefMask,
  output logic      [4:0]             logIndex
);

  stlog_top_state_t       s_q;
  stlog_top_state_t       s_d;
  logic [7:0]             spanRdByte;
  logic [`STL_NSPANS-1:0] spanHit;
  logic [`STL_NSPANS-1:0] spanDef;
  logic                   spanWr;
  logic [4:0]             nextIdx;
  logic [4:0]             slot;
  stlog_desc_t            newDesc;
  logic [8:0]             relOfs;
  logic [4:0]             entrySel;
  logic [4:0]             byteSel;

  // Byte n of a descriptor; multi-byte fields are little-endian
  function automatic logic [7:0] descByte(input stlog_desc_t d, input logic [4:0] b);
    case (b)
      5'h00:   return d.secNum;
      5'h01:   return d.status;
      5'h02:   return d.hours[7:0];
      5'h03:   return d.hours[15:8];
      5'h04:   return d.chkpt;
      5'h05:   return d.failLba[7:0];
      5'h06:   return d.failLba[15:8];
      5'h07:   return d.failLba[23:16];
      5'h08:   return d.failLba[31:24];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] descSum(input stlog_desc_t d);
    logic [7:0] acc;
    acc = 8'h00;
    for (int b = 0; b < 9; b++) begin
      acc = acc + descByte(d, 5'(b));
    end
    return acc;
  endfunction

  function automatic logic inDesc(input logic [8:0] ofs);
    return (ofs >= `STL_DESC_FIRST) && (ofs <= `STL_DESC_LAST);
  endfunction

  stlog_span_table u_span (
    .core_clk (core_clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .wrEn     (spanWr),
    .byteOfs  (hostByteOfs),
    .wrData   (hostWrData),
    .rdByte   (spanRdByte),
    .queryLba (spanQueryLba),
    .hitMask  (spanHit),
    .defMask  (spanDef)
  );

  // Writes to the span table are dropped while a selective test runs so the engine never sees torn bounds
  assign spanWr = hostWrEn && (hostLogAddr == `STL_LOG_SELECT) && !selectiveBusy;

  // Empty log and the last slot both lead to slot one
  assign nextIdx = ((s_q.idx == `STL_IDX_EMPTY) || (s_q.idx == `STL_IDX_LAST)) ?
                   `STL_IDX_FIRST : 5'(s_q.idx + 5'h01);
  assign slot    = 5'(nextIdx - 5'h01);

  assign relOfs   = 9'(hostByteOfs - `STL_DESC_FIRST);
  assign entrySel = 5'(relOfs / `STL_DESC_BYTES);
  assign byteSel  = 5'(relOfs % `STL_DESC_BYTES);

  always_comb begin
    newDesc.secNum  = s_q.secNum;
    newDesc.status  = testStatus;
    newDesc.hours   = powerOnHours;
    newDesc.chkpt   = testChkpt;
    // First uncorrectable sector wins, including one flagged in the completion cycle
    if (s_q.uncSeen) begin
      newDesc.failLba = s_q.uncLba;
    end else if (testUncErr) begin
      newDesc.failLba = testUncLba;
    end else begin
      newDesc.failLba = 32'h0000_0000;
    end
  end

  always_comb begin
    s_d           = s_q;
    s_d.rdValid   = 1'b0;
    s_d.wrRefused = 1'b0;

    if (testStart) begin
      s_d.phase   = STL_RUN;
      s_d.secNum  = testSecNum;
      s_d.uncSeen = 1'b0;
      s_d.uncLba  = 32'h0000_0000;
    end else if (s_q.phase == STL_RUN) begin
      if (testUncErr && !s_q.uncSeen) begin
        s_d.uncSeen = 1'b1;
        s_d.uncLba  = testUncLba;
      end
      if (testDone) begin
        // Index, slot and running sum move in the same edge, so a read never sees half an entry
        s_d.phase     = STL_IDLE;
        s_d.mem[slot] = newDesc;
        s_d.idx       = nextIdx;
        s_d.sum       = 8'(s_q.sum - descSum(s_q.mem[slot]) + descSum(newDesc)
                           - {3'b000, s_q.idx} + {3'b000, nextIdx});
        if (nextIdx == `STL_IDX_LAST) begin
          s_d.full = 1'b1;
        end
      end
    end

    if (hostRdEn) begin
      s_d.rdValid = 1'b1;
      s_d.rdData  = 8'h00;
      case (hostLogAddr)
        `STL_LOG_RESULT: begin
          if (hostByteOfs == 9'h000) begin
            s_d.rdData = `STL_REV_LO;
          end else if (hostByteOfs == `STL_OFS_REV_HI) begin
            s_d.rdData = `STL_REV_HI;
          end else if (inDesc(hostByteOfs)) begin
            // Never-written slots stay at their reset value of zero
            s_d.rdData = descByte(s_q.mem[entrySel], byteSel);
          end else if (hostByteOfs == `STL_OFS_INDEX) begin
            s_d.rdData = {3'b000, s_q.idx};
          end else if (hostByteOfs == `STL_OFS_CSUM) begin
            s_d.rdData = 8'(8'h00 - s_q.sum);
          end
        end
        `STL_LOG_SELECT: begin
          s_d.rdData = spanRdByte;
        end
        default: begin
          s_d.rdData = 8'h00;
        end
      endcase
    end

    // The result log is read-only; span writes during a selective test are dropped
    if (hostWrEn && !spanWr) begin
      s_d.wrRefused = 1'b1;
    end

    s_d.hitMask = spanHit;
    s_d.defMask = spanDef;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q     <= '0;
      s_q.sum <= `STL_REV_LO;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign hostRdData    = s_q.rdData;
  assign hostRdValid   = s_q.rdValid;
  assign hostWrRefused = s_q.wrRefused;
  assign spanHitMask   = s_q.hitMask;
  assign spanDefMask   = s_q.defMask;
  assign logIndex      = s_q.idx;

  // Helper for checking: sum of bytes 0 to 510, without the checksum byte, computed directly from the stored image
  logic [7:0] chkSectorSum;
  always_comb begin
    chkSectorSum = 8'(`STL_REV_LO + `STL_REV_HI + {3'b000, s_q.idx});
    for (int e = 0; e < `STL_NSLOTS; e++) begin
      chkSectorSum = chkSectorSum + descSum(s_q.mem[e]);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_rd_result(logic [8:0] ofs);
    clkEn && hostRdEn && hostLogAddr == `STL_LOG_RESULT && hostByteOfs == ofs;
  endsequence

  sequence s_start_then_done;
    clkEn && testStart ##1 clkEn && testDone && !testStart;
  endsequence

  property p_rev_read;
    s_rd_result(9'h000) |=> hostRdValid && hostRdData == `STL_REV_LO;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision low byte wrong");

  property p_empty_index;
    s_rd_result(`STL_OFS_INDEX) and (s_q.idx == `STL_IDX_EMPTY) |=> hostRdData == 8'h00;
  endproperty
  a_empty_index: assert property (p_empty_index) else $error("empty log index not zero");

  property p_index_wrap;
    clkEn && testDone && !testStart && s_q.phase == STL_RUN && s_q.idx == `STL_IDX_LAST
      |=> s_q.idx == `STL_IDX_FIRST && s_q.full;
  endproperty
  a_index_wrap: assert property (p_index_wrap) else $error("index did not wrap to one");

  property p_index_step;
    clkEn && testDone && !testStart && s_q.phase == STL_RUN && s_q.idx != `STL_IDX_LAST
      |=> s_q.idx == 5'($past(s_q.idx) + 5'h01);
  endproperty
  a_index_step: assert property (p_index_step) else $error("index did not advance by one");

  property p_unused_zero;
    !s_q.full && s_q.idx != `STL_IDX_LAST |-> s_q.mem[s_q.idx] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused slot not zero");

  property p_secnum_capture;
    s_start_then_done |=> s_q.mem[5'(s_q.idx - 5'h01)].secNum == $past(testSecNum, 2)
      && s_q.mem[5'(s_q.idx - 5'h01)].status == $past(testStatus);
  endproperty
  a_secnum_capture: assert property (p_secnum_capture) else $error("entry fields not captured");

  property p_hours_capture;
    clkEn && testDone && !testStart && s_q.phase == STL_RUN
      |=> s_q.mem[5'(s_q.idx - 5'h01)].hours == $past(powerOnHours);
  endproperty
  a_hours_capture: assert property (p_hours_capture) else $error("lifetime hours not captured");

  property p_first_unc;
    clkEn && testStart ##1 clkEn && testUncErr && !testDone && !testStart
      ##1 clkEn && testDone && !testStart
      |=> s_q.mem[5'(s_q.idx - 5'h01)].failLba == $past(testUncLba, 2);
  endproperty
  a_first_unc: assert property (p_first_unc) else $error("failing address not the first one");

  property p_checksum;
    (8'(chkSectorSum + s_q.sum) == 8'(2 * chkSectorSum)) && chkSectorSum == s_q.sum;
  endproperty
  a_checksum: assert property (p_checksum) else $error("sector does not sum to zero");

  property p_busy_refuse;
    clkEn && hostWrEn && hostLogAddr == `STL_LOG_SELECT && selectiveBusy |=> hostWrRefused;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write during selective test accepted");

endmodule

/* File: verif/stlog_host_model.sv */
// Host-side model: reads whole log sectors a byte per cycle and writes selective span bounds.
// Assumes it drives at the falling edge of core_clk and the device samples on the rising edge.
`timescale 1ns/1ps
`include "stlog_map.svh"

module stlog_host_model (
  // Clock and device state
  input  wire logic       core_clk,
  input  wire logic       selectiveBusy,
  // Host log access
  output logic            hostRdEn,
  output logic            hostWrEn,
  output logic [7:0]      hostLogAddr,
  output logic [8:0]      hostByteOfs,
  output logic [7:0]      hostWrData,
  input  wire logic [7:0] hostRdData,
  input  wire logic       hostRdValid,
  input  wire logic       hostWrRefused
);
  logic [7:0] secBuf [0:511];
  logic       rdOk;

  initial begin
    hostRdEn    = 1'b0;
    hostWrEn    = 1'b0;
    hostLogAddr = 8'h00;
    hostByteOfs = 9'h000;
    hostWrData  = 8'h00;
  end

  // Released qualifiers flip so a stale value can never pass for a fresh one
  task automatic releaseBus();
    hostLogAddr = ~hostLogAddr;
    hostByteOfs = ~hostByteOfs;
    hostWrData  = ~hostWrData;
  endtask

  // Pipelined: byte i is requested while byte i-1 is collected
  task automatic readSector(input logic [7:0] log);
    rdOk = 1'b1;
    for (int i = 0; i <= 512; i++) begin
      @(negedge core_clk);
      if (i > 0) begin
        secBuf[i-1] = hostRdData;
        if (hostRdValid !== 1'b1) rdOk = 1'b0;
      end
      if (i < 512) begin
        hostRdEn    = 1'b1;
        hostLogAddr = log;
        hostByteOfs = i[8:0];
      end else begin
        hostRdEn = 1'b0;
        releaseBus();
      end
    end
  endtask

  // A rude write ignores the busy level; only refusal scenarios ask for it
  task automatic writeByte(input logic [7:0] log, input logic [8:0] ofs, input logic [7:0] data,
                           input logic rude, output logic refused);
    if (!rude) while (selectiveBusy === 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    hostWrEn    = 1'b1;
    hostLogAddr = log;
    hostByteOfs = ofs;
    hostWrData  = data;
    @(negedge core_clk);
    refused  = hostWrRefused;
    hostWrEn = 1'b0;
    releaseBus();
  endtask

  // Start and end bounds, eight bytes each, low byte first
  task automatic writeSpan(input int idx, input logic [63:0] st, input logic [63:0] en);
    logic r;
    for (int b = 0; b < 16; b++)
      writeByte(`STL_LOG_SELECT, 9'(2 + 16 * idx + b), b < 8 ? st[8*b +: 8] : en[8*(b-8) +: 8], 1'b0, r);
  endtask
endmodule

/* File: verif/stlog_result_log_tb.sv */
// Self-checking bench for the self-test result log and selective span table.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
`include "stlog_map.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin failCount++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (act), (exp)); end end

module stlog_result_log_tb;
  import stlog_pkg::*;
  logic core_clk, reset, clkEn, hostRdEn, hostWrEn, hostRdValid, hostWrRefused;
  logic testStart, testUncErr, testDone, selectiveBusy, refused;
  logic [7:0]  hostLogAddr, hostWrData, hostRdData, testSecNum, testStatus, testChkpt;
  logic [8:0]  hostByteOfs;
  logic [31:0] testUncLba;
  logic [15:0] powerOnHours;
  logic [63:0] spanQueryLba, lba;
  logic [4:0]  spanHitMask, spanDefMask, logIndex, mIdx;
  logic [7:0]  mSec [21], mSt [21], mChk [21], selImg [0:81];
  logic [15:0] mHrs [21];
  logic [31:0] mLba [21];
  logic        mLbaOk [21];
  logic [63:0] spSt [5], spEn [5];
  int          seed = 32'h5508CF3B;
  int          nUsed, checked, failCount;

  always #50 core_clk = ~core_clk;

  stlog_host_model host_i (.core_clk(core_clk), .selectiveBusy(selectiveBusy), .hostRdEn(hostRdEn),
    .hostWrEn(hostWrEn), .hostLogAddr(hostLogAddr), .hostByteOfs(hostByteOfs), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid), .hostWrRefused(hostWrRefused));

  stlog_result_log stlog_result_log_i (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
    .hostRdEn(hostRdEn), .hostWrEn(hostWrEn), .hostLogAddr(hostLogAddr), .hostByteOfs(hostByteOfs),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .hostWrRefused(hostWrRefused), .testStart(testStart), .testSecNum(testSecNum),
    .testUncErr(testUncErr), .testUncLba(testUncLba), .testDone(testDone), .testStatus(testStatus),
    .testChkpt(testChkpt), .powerOnHours(powerOnHours), .selectiveBusy(selectiveBusy),
    .spanQueryLba(spanQueryLba), .spanHitMask(spanHitMask), .spanDefMask(spanDefMask),
    .logIndex(logIndex));

  function automatic logic [7:0] expByte(input logic [7:0] log, input int ofs);
    int          s;
    int          b;
    logic [71:0] d;
    expByte = 8'h00;
    s = (ofs - 2) / 24;
    b = (ofs - 2) % 24;
    if (log == `STL_LOG_SELECT && ofs <= `STL_SEL_LAST) expByte = selImg[ofs];
    else if (log == `STL_LOG_RESULT) begin
      if (ofs == 0) expByte = `STL_REV_LO;
      else if (ofs == 1) expByte = `STL_REV_HI;
      else if (ofs == 508) expByte = {3'h0, mIdx};
      else if (ofs >= 2 && ofs <= 505 && s < nUsed && b < 9) begin
        d = {mLba[s], mChk[s], mHrs[s], mSt[s], mSec[s]};
        expByte = d[8*b +: 8];
      end
    end
  endfunction

  function automatic logic [4:0] expHit(input logic [63:0] q, input logic defOnly);
    expHit = 5'h00;
    for (int k = 0; k < 5; k++)
      expHit[k] = (spSt[k] != 0 || spEn[k] != 0) && (defOnly || (q >= spSt[k] && q <= spEn[k]));
  endfunction

  task automatic checkSector(input logic [7:0] log);
    logic [7:0] sum;
    int         s;
    int         b;
    sum = 8'h00;
    host_i.readSector(log);
    `CHK(host_i.rdOk, 1'b1)
    for (int i = 0; i < 512; i++) begin
      s = (i - 2) / 24;
      b = (i - 2) % 24;
      if (log == `STL_LOG_RESULT && i == 511) `CHK(host_i.secBuf[i], 8'h00 - sum)
      else if (i < 2) `CHK(host_i.secBuf[i], expByte(log, i))
      else if (i == 508) `CHK(host_i.secBuf[i], expByte(log, i))
      // Failing address carries no promise when no uncorrectable sector was met
      else if (log == `STL_LOG_RESULT && i <= 505 && b >= 5 && b <= 8 && s < nUsed && !mLbaOk[s]);
      else `CHK(host_i.secBuf[i], expByte(log, i))
      sum += host_i.secBuf[i];
    end
  endtask

  task automatic runTest(input int nUnc);
    logic [4:0] nxt;
    int         s;
    nxt = (mIdx == `STL_IDX_LAST) ? `STL_IDX_FIRST : mIdx + 5'h01;
    s = nxt - 1;
    @(negedge core_clk);
    testStart  = 1'b1;
    testSecNum = 8'($random(seed));
    mSec[s]    = testSecNum;
    mLbaOk[s]  = nUnc > 0;
    @(negedge core_clk);
    testStart = 1'b0;
    for (int u = 0; u < nUnc; u++) begin
      testUncErr = 1'b1;
      testUncLba = $random(seed);
      if (u == 0) mLba[s] = testUncLba;
      @(negedge core_clk);
    end
    testUncErr   = 1'b0;
    testDone     = 1'b1;
    testStatus   = 8'($random(seed));
    testChkpt    = 8'($random(seed));
    powerOnHours = 16'($random(seed));
    mSt[s]       = testStatus;
    mChk[s]      = testChkpt;
    mHrs[s]      = powerOnHours;
    @(negedge core_clk);
    testDone = 1'b0;
    mIdx     = nxt;
    if (nUsed < `STL_NSLOTS) nUsed++;
    `CHK(logIndex, mIdx)
    checkSector(`STL_LOG_RESULT);
  endtask

  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    failCount++;
    stopTest();
  end

  initial begin
    {core_clk, reset, clkEn, testStart, testUncErr, testDone, selectiveBusy} = 7'b0110000;
    {testSecNum, testStatus, testChkpt, testUncLba, powerOnHours, spanQueryLba} = '0;
    mIdx  = `STL_IDX_EMPTY;
    nUsed = 0;
    for (int i = 0; i <= `STL_SEL_LAST; i++) selImg[i] = 8'h00;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    // A start seen while frozen is lost, so the completion below finds no test running
    clkEn     = 1'b0;
    testStart = 1'b1;
    @(negedge core_clk);
    testStart = 1'b0;
    clkEn     = 1'b1;
    // A completion with no test running must leave the log empty
    testDone = 1'b1;
    @(negedge core_clk);
    testDone = 1'b0;
    @(negedge core_clk);
    `CHK(logIndex, 5'h00)
    checkSector(`STL_LOG_RESULT);
    @(negedge core_clk);
    `CHK(hostRdValid, 1'b0)
    checkSector(8'h07);
    host_i.writeByte(`STL_LOG_RESULT, 9'h002, 8'hA5, 1'b1, refused);
    `CHK(refused, 1'b1)
    for (int t = 0; t < 23; t++) runTest(t % 3);
    // Span 1 is both-zero, span 2 starts at zero but is still defined
    for (int k = 0; k < 5; k++) begin
      spSt[k] = {33'h0, 31'($random(seed))};
      spEn[k] = spSt[k] + 64'($random(seed) & 32'hFF);
    end
    {spSt[1], spEn[1], spSt[2], spEn[2]} = {64'h0, 64'h0, 64'h0, 64'h5};
    host_i.writeByte(`STL_LOG_SELECT, 9'h000, 8'h01, 1'b0, refused);
    host_i.writeByte(`STL_LOG_SELECT, 9'h001, 8'h00, 1'b0, refused);
    selImg[0] = 8'h01;
    for (int k = 0; k < 5; k++) begin
      host_i.writeSpan(k, spSt[k], spEn[k]);
      for (int b = 0; b < 8; b++) {selImg[2+16*k+b+8], selImg[2+16*k+b]} = {spEn[k][8*b +: 8], spSt[k][8*b +: 8]};
    end
    checkSector(`STL_LOG_SELECT);
    for (int q = 0; q < 30; q++) begin
      case ((q / 5) % 4)
        0: lba = spSt[q % 5] - 64'h1;
        1: lba = spSt[q % 5];
        2: lba = spEn[q % 5];
        default: lba = spEn[q % 5] + 64'h1;
      endcase
      if (q >= 20) lba = spSt[q % 5] + 64'($random(seed) & 32'h1FF);
      spanQueryLba = lba;
      @(negedge core_clk);
      @(negedge core_clk);
      `CHK(spanHitMask, expHit(lba, 1'b0))
      `CHK(spanDefMask, expHit(lba, 1'b1))
    end
    selectiveBusy = 1'b1;
    host_i.writeByte(`STL_LOG_SELECT, 9'h002, ~selImg[2], 1'b1, refused);
    `CHK(refused, 1'b1)
    selectiveBusy = 1'b0;
    host_i.writeByte(`STL_LOG_SELECT, 9'h0AA, 8'h5A, 1'b0, refused);
    `CHK(refused, 1'b0)
    checkSector(`STL_LOG_SELECT);
    // Reset in mid-run must empty both sectors again
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    mIdx  = `STL_IDX_EMPTY;
    nUsed = 0;
    for (int i = 0; i <= `STL_SEL_LAST; i++) selImg[i] = 8'h00;
    `CHK(logIndex, 5'h00)
    checkSector(`STL_LOG_RESULT);
    checkSector(`STL_LOG_SELECT);
    stopTest();
  end
endmodule
